// file: rtl/iefb_defs.svh
`ifndef IEFB_DEFS_SVH
`define IEFB_DEFS_SVH

// ==========================================================================
// register select codes on the special-purpose data memory port
`define IEFB_SEL_CTRL_A 3'h0
`define IEFB_SEL_CTRL_B 3'h1
`define IEFB_SEL_TMR0 3'h2
`define IEFB_SEL_TMR1 3'h3
`define IEFB_SEL_TMR2 3'h4

// ==========================================================================
// primary_irq_ctrl_a bit positions
`define IEFB_A_GLOBAL_EN 0
`define IEFB_A_TICK_EN 1
`define IEFB_A_GRP0_EN 2
`define IEFB_A_GRP1_EN 3
`define IEFB_A_TICK_F 4
`define IEFB_A_GRP0_F 5
`define IEFB_A_GRP1_F 6

// ==========================================================================
// primary_irq_ctrl_b bit positions
`define IEFB_B_GRP2_EN 0
`define IEFB_B_CHAIN_EN 1
`define IEFB_B_GRP2_F 4
`define IEFB_B_CHAIN_F 5

// ==========================================================================
// timerN_match_irq_ctrl bit positions
`define IEFB_T_PERIOD_EN 0
`define IEFB_T_DUTY_EN 1
`define IEFB_T_PERIOD_F 4
`define IEFB_T_DUTY_F 5

// ==========================================================================
// flag bank layout and reset values
`define IEFB_NUM_FLAGS 11
`define IEFB_NUM_VEC 5
`define IEFB_NUM_TMR 3
`define IEFB_FLG_GRP0 0
`define IEFB_FLG_TICK 3
`define IEFB_FLG_CHAIN 4
`define IEFB_FLG_TP0 5
`define IEFB_FLG_TD0 8
`define IEFB_RST_FLAGS 11'h000
`define IEFB_RST_REG 8'h00

`endif

// file: rtl/iefb_pkg.sv
package iefb_pkg;

	// ======================================================================
	// vector numbers, equal to the direct flag index and irq line
	typedef enum logic [2:0] {
		IEFB_VEC_GRP0 = 3'h0,
		IEFB_VEC_GRP1 = 3'h1,
		IEFB_VEC_GRP2 = 3'h2,
		IEFB_VEC_TICK = 3'h3,
		IEFB_VEC_CHAIN = 3'h4
	} iefb_vec_t;

	// ======================================================================
	// register port request from the core
	typedef struct packed {
		logic wr;
		logic [2:0] sel;
		logic [7:0] wdata;
	} iefb_regreq_t;

	// timer comparator match pulses, one bit per timer
	typedef struct packed {
		logic [2:0] period;
		logic [2:0] duty;
	} iefb_tmr_evt_t;

	// chained serial transceiver event pulses
	typedef struct packed {
		logic fmt_err;
		logic link_reset;
		logic tx_empty;
		logic rx_full;
	} iefb_chain_evt_t;

	// core acknowledge of a vector being taken
	typedef struct packed {
		logic ack;
		iefb_vec_t vec;
	} iefb_svc_t;

endpackage

// file: rtl/iefb_flag_bank.sv
`timescale 1ns/10ps
`include "iefb_defs.svh"

module iefb_flag_bank (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// per-flag controls
	input wire logic [`IEFB_NUM_FLAGS-1:0] set_hw,
	input wire logic [`IEFB_NUM_FLAGS-1:0] wr_en,
	input wire logic [`IEFB_NUM_FLAGS-1:0] wr_val,
	input wire logic [`IEFB_NUM_FLAGS-1:0] clr,
	// stored flags
	output logic [`IEFB_NUM_FLAGS-1:0] flag_q
);

	logic [`IEFB_NUM_FLAGS-1:0] flag_d;

	// set beats write beats service clear, so no event is lost
	assign flag_d = set_hw | (wr_en & wr_val) | (~wr_en & flag_q & ~clr);

	// flag storage
	always_ff @(posedge core_clk) begin
		if (reset) begin
			flag_q <= `IEFB_RST_FLAGS;
		end else begin
			flag_q <= flag_d;
		end
	end

endmodule // iefb_flag_bank

// file: rtl/iefb_irq_bank.sv
`timescale 1ns/10ps
`include "iefb_defs.svh"


module iefb_irq_bank (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire iefb_pkg::iefb_regreq_t reg_req,
	output logic [7:0] reg_rdata_q,
	// peripheral events
	input wire logic tick_evt,
	input wire iefb_pkg::iefb_tmr_evt_t tmr_evt,
	input wire iefb_pkg::iefb_chain_evt_t chain_evt,
	// core vectoring
	input wire iefb_pkg::iefb_svc_t svc,
	output logic [`IEFB_NUM_VEC-1:0] irq_req_q
);

	// ======================================================================
	// helpers
	function automatic logic hit(input logic [2:0] sel,
		input logic [2:0] code);
		hit = (sel == code);
	endfunction

	function automatic logic [7:0] pack_tmr(input logic df, input logic pf,
		input logic de, input logic pe);
		logic [7:0] r;
		r = `IEFB_RST_REG;
		r[`IEFB_T_DUTY_F] = df;
		r[`IEFB_T_PERIOD_F] = pf;
		r[`IEFB_T_DUTY_EN] = de;
		r[`IEFB_T_PERIOD_EN] = pe;
		pack_tmr = r;
	endfunction

	// ======================================================================
	// state
	logic global_en_q;
	logic tick_en_q;
	logic chain_en_q;
	logic [2:0] grp_en_q;
	logic [2:0] tp_en_q;
	logic [2:0] td_en_q;
	logic [2:0] grp_src_q;
	logic [`IEFB_NUM_FLAGS-1:0] flag_q;

	// ======================================================================
	// write decode
	logic wr_a;
	logic wr_b;
	logic [2:0] wr_t;
	logic [7:0] wd;

	assign wd = reg_req.wdata;
	assign wr_a = reg_req.wr && hit(reg_req.sel, `IEFB_SEL_CTRL_A);
	assign wr_b = reg_req.wr && hit(reg_req.sel, `IEFB_SEL_CTRL_B);
	assign wr_t[0] = reg_req.wr && hit(reg_req.sel, `IEFB_SEL_TMR0);
	assign wr_t[1] = reg_req.wr && hit(reg_req.sel, `IEFB_SEL_TMR1);
	assign wr_t[2] = reg_req.wr && hit(reg_req.sel, `IEFB_SEL_TMR2);

	// ======================================================================
	// flag controls
	logic [`IEFB_NUM_FLAGS-1:0] fl_set;
	logic [`IEFB_NUM_FLAGS-1:0] fl_wr;
	logic [`IEFB_NUM_FLAGS-1:0] fl_val;
	logic [`IEFB_NUM_FLAGS-1:0] fl_clr;
	logic [`IEFB_NUM_VEC-1:0] svc_clr;
	logic [2:0] grp_src;
	logic [2:0] grp_set;

	// group source: an enabled timer flag; edge keeps a serviced group quiet
	genvar n;
	generate
		for (n = 0; n < `IEFB_NUM_TMR; n++) begin : g_grp
			assign grp_src[n] =
				(flag_q[`IEFB_FLG_TP0+n] & tp_en_q[n]) |
				(flag_q[`IEFB_FLG_TD0+n] & td_en_q[n]);
			assign grp_set[n] = grp_src[n] & ~grp_src_q[n];
			assign fl_set[`IEFB_FLG_TP0+n] = tmr_evt.period[n];
			assign fl_set[`IEFB_FLG_TD0+n] = tmr_evt.duty[n];
			assign fl_wr[`IEFB_FLG_TP0+n] = wr_t[n];
			assign fl_wr[`IEFB_FLG_TD0+n] = wr_t[n];
			assign fl_val[`IEFB_FLG_TP0+n] = wd[`IEFB_T_PERIOD_F];
			assign fl_val[`IEFB_FLG_TD0+n] = wd[`IEFB_T_DUTY_F];
		end
	endgenerate

	// direct vector flags and their set sources
	assign fl_set[2:0] = grp_set;
	assign fl_set[`IEFB_FLG_TICK] = tick_evt;
	assign fl_set[`IEFB_FLG_CHAIN] = chain_evt.fmt_err |
		chain_evt.link_reset | chain_evt.tx_empty | chain_evt.rx_full;
	assign fl_wr[`IEFB_FLG_GRP0] = wr_a;
	assign fl_wr[`IEFB_FLG_GRP0+1] = wr_a;
	assign fl_wr[`IEFB_FLG_GRP0+2] = wr_b;
	assign fl_wr[`IEFB_FLG_TICK] = wr_a;
	assign fl_wr[`IEFB_FLG_CHAIN] = wr_b;
	assign fl_val[`IEFB_FLG_GRP0] = wd[`IEFB_A_GRP0_F];
	assign fl_val[`IEFB_FLG_GRP0+1] = wd[`IEFB_A_GRP1_F];
	assign fl_val[`IEFB_FLG_GRP0+2] = wd[`IEFB_B_GRP2_F];
	assign fl_val[`IEFB_FLG_TICK] = wd[`IEFB_A_TICK_F];
	assign fl_val[`IEFB_FLG_CHAIN] = wd[`IEFB_B_CHAIN_F];

	// service clears only the direct flag of the taken vector
	assign svc_clr = svc.ack ? (5'h01 << svc.vec) : 5'h00;
	assign fl_clr = {6'h00, svc_clr};

	iefb_flag_bank u_flags (
		.core_clk(core_clk),
		.reset(reset),
		.set_hw(fl_set),
		.wr_en(fl_wr),
		.wr_val(fl_val),
		.clr(fl_clr),
		.flag_q(flag_q)
	);

	// ======================================================================
	// enable registers
	// global enable: service wins over a write in the same cycle, so a
	// vector can never be taken twice before the handler runs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			global_en_q <= 1'b0;
		end else if (svc.ack) begin
			global_en_q <= 1'b0;
		end else if (wr_a) begin
			global_en_q <= wd[`IEFB_A_GLOBAL_EN];
		end
	end

	// primary source enables
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tick_en_q <= 1'b0;
			grp_en_q <= 3'h0;
			chain_en_q <= 1'b0;
		end else begin
			if (wr_a) begin
				tick_en_q <= wd[`IEFB_A_TICK_EN];
				grp_en_q[0] <= wd[`IEFB_A_GRP0_EN];
				grp_en_q[1] <= wd[`IEFB_A_GRP1_EN];
			end
			if (wr_b) begin
				grp_en_q[2] <= wd[`IEFB_B_GRP2_EN];
				chain_en_q <= wd[`IEFB_B_CHAIN_EN];
			end
		end
	end

	// timer match enables and group source history
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tp_en_q <= 3'h0;
			td_en_q <= 3'h0;
			grp_src_q <= 3'h0;
		end else begin
			for (int i = 0; i < `IEFB_NUM_TMR; i++) begin
				if (wr_t[i]) begin
					tp_en_q[i] <= wd[`IEFB_T_PERIOD_EN];
					td_en_q[i] <= wd[`IEFB_T_DUTY_EN];
				end
			end
			grp_src_q <= grp_src;
		end
	end

	// ======================================================================
	// request lines and read data
	logic [`IEFB_NUM_VEC-1:0] en_dir;
	logic [`IEFB_NUM_VEC-1:0] irq_d;
	logic [7:0] rd_a;
	logic [7:0] rd_b;
	logic [7:0] rd_t0;
	logic [7:0] rd_t1;
	logic [7:0] rd_t2;
	logic [7:0] rdata_d;

	// disabled flags stay set but are masked here
	assign en_dir = {chain_en_q, tick_en_q, grp_en_q};
	assign irq_d = flag_q[`IEFB_NUM_VEC-1:0] & en_dir &
		{`IEFB_NUM_VEC{global_en_q}};

	// register images, unimplemented bits tied low
	assign rd_a = {1'b0, flag_q[1], flag_q[0], flag_q[`IEFB_FLG_TICK],
		grp_en_q[1], grp_en_q[0], tick_en_q, global_en_q};
	assign rd_b = {2'h0, flag_q[`IEFB_FLG_CHAIN], flag_q[2],
		2'h0, chain_en_q, grp_en_q[2]};
	assign rd_t0 = pack_tmr(flag_q[`IEFB_FLG_TD0], flag_q[`IEFB_FLG_TP0],
		td_en_q[0], tp_en_q[0]);
	assign rd_t1 = pack_tmr(flag_q[`IEFB_FLG_TD0+1],
		flag_q[`IEFB_FLG_TP0+1], td_en_q[1], tp_en_q[1]);
	assign rd_t2 = pack_tmr(flag_q[`IEFB_FLG_TD0+2],
		flag_q[`IEFB_FLG_TP0+2], td_en_q[2], tp_en_q[2]);
	assign rdata_d = hit(reg_req.sel, `IEFB_SEL_CTRL_A) ? rd_a :
		hit(reg_req.sel, `IEFB_SEL_CTRL_B) ? rd_b :
		hit(reg_req.sel, `IEFB_SEL_TMR0) ? rd_t0 :
		hit(reg_req.sel, `IEFB_SEL_TMR1) ? rd_t1 :
		hit(reg_req.sel, `IEFB_SEL_TMR2) ? rd_t2 : `IEFB_RST_REG;

	// outputs straight from flops; one cycle behind the state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_req_q <= 5'h00;
			reg_rdata_q <= `IEFB_RST_REG;
		end else begin
			irq_req_q <= irq_d;
			reg_rdata_q <= rdata_d;
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_fresh_match;
		tmr_evt.period[0] && tp_en_q[0] && !grp_src[0] && !reg_req.wr;
	endsequence

	sequence s_quiet_port;
		!reg_req.wr;
	endsequence

	sequence s_tick_svc;
		svc.ack && svc.vec == iefb_pkg::IEFB_VEC_TICK && !tick_evt && !wr_a;
	endsequence

	a_global_gates_all: assert property (
		!global_en_q |=> irq_req_q == 5'h00)
		else $error("request line high with global enable off");

	a_tick_delivery: assert property (
		flag_q[`IEFB_FLG_TICK] && tick_en_q && global_en_q
		|=> irq_req_q[`IEFB_FLG_TICK])
		else $error("enabled tick request not presented");

	a_disabled_kept: assert property (
		flag_q[`IEFB_FLG_CHAIN] && !chain_en_q && !wr_b && !svc.ack
		|=> flag_q[`IEFB_FLG_CHAIN] && !irq_req_q[`IEFB_FLG_CHAIN])
		else $error("disabled chain request lost or delivered");

	a_set_beats_write: assert property (
		tick_evt && wr_a && !wd[`IEFB_A_TICK_F]
		|=> flag_q[`IEFB_FLG_TICK])
		else $error("tick event lost to a clearing write");

	a_chain_sources: assert property (
		(chain_evt.fmt_err || chain_evt.link_reset ||
		chain_evt.tx_empty || chain_evt.rx_full)
		|=> flag_q[`IEFB_FLG_CHAIN] ##1
		reg_rdata_q[`IEFB_B_CHAIN_F] || $past(reg_req.sel) !=
		`IEFB_SEL_CTRL_B)
		else $error("chain link flag not set by transceiver event");

	a_service_clears: assert property (
		s_tick_svc |=> !flag_q[`IEFB_FLG_TICK] && !global_en_q ##1
		!irq_req_q[`IEFB_FLG_TICK])
		else $error("service left tick flag or global enable set");

	a_group_from_timer: assert property (
		s_fresh_match ##1 s_quiet_port |=> flag_q[`IEFB_FLG_GRP0])
		else $error("timer match did not raise group 0 flag");

	a_source_survives: assert property (
		svc.ack && svc.vec == iefb_pkg::IEFB_VEC_GRP0 && !wr_t[0] &&
		flag_q[`IEFB_FLG_TP0] |=> flag_q[`IEFB_FLG_TP0])
		else $error("service cleared a timer source flag");

	a_reserved_zero: assert property (
		reg_rdata_q[7] == 1'b0 &&
		($past(reg_req.sel) == `IEFB_SEL_CTRL_A ||
		(reg_rdata_q[7:6] == 2'h0 && reg_rdata_q[3:2] == 2'h0)))
		else $error("unimplemented register bit read as one");

	a_reset_clear: assert property (
		$past(reset) |-> flag_q == `IEFB_RST_FLAGS && !global_en_q &&
		!tick_en_q && !chain_en_q && irq_req_q == 5'h00 &&
		reg_rdata_q == `IEFB_RST_REG &&
		tp_en_q == 3'h0 && td_en_q == 3'h0 && grp_en_q == 3'h0)
		else $error("state not cleared by reset");

	a_timer_enable_wr: assert property (
		wr_t[1] |=> tp_en_q[1] == $past(wd[`IEFB_T_PERIOD_EN]) &&
		td_en_q[1] == $past(wd[`IEFB_T_DUTY_EN]))
		else $error("timer 1 enable write not stored");

endmodule // iefb_irq_bank

// file: test/iefb_core_model.sv
`timescale 1ns/10ps

// ==========================================================================
// core vectoring model: takes the lowest raised line after a wait
module iefb_core_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// request lines and wait setting
	input wire logic [4:0] irq_req_q,
	input wire logic [3:0] lag,
	// acknowledge back to the bank
	output iefb_pkg::iefb_svc_t svc
);
	logic [3:0] cnt_q;
	logic [2:0] hold_q;

	function automatic iefb_pkg::iefb_vec_t lowest(input logic [4:0] l);
		for (int k = 4; k >= 0; k--) begin
			if (l[k]) begin
				lowest = iefb_pkg::iefb_vec_t'(k[2:0]);
			end
		end
	endfunction

	// hold-off after an ack: the line drops two edges late, so no re-take
	always @(negedge core_clk) begin
		svc.ack <= 1'b0;
		svc.vec <= iefb_pkg::iefb_vec_t'(~svc.vec);
		if (reset) begin
			cnt_q <= 4'h0;
			hold_q <= 3'h0;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end else if (irq_req_q != 5'h00) begin
			if (cnt_q >= lag) begin
				svc.ack <= 1'b1;
				svc.vec <= lowest(irq_req_q);
				cnt_q <= 4'h0;
				hold_q <= 3'h4;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end else begin
			cnt_q <= 4'h0;
		end
	end
endmodule // iefb_core_model

// file: test/iefb_irq_bank_tb_top.sv
`timescale 1ns/10ps

module iefb_irq_bank_tb_top;
	logic core_clk, reset, tick_evt;
	iefb_pkg::iefb_regreq_t reg_req;
	iefb_pkg::iefb_tmr_evt_t tmr_evt;
	iefb_pkg::iefb_chain_evt_t chain_evt;
	iefb_pkg::iefb_svc_t svc;
	logic [7:0] reg_rdata_q;
	logic [4:0] irq_req_q;
	logic [3:0] lag;
	int fails, compares;

	iefb_irq_bank dut_u (.core_clk(core_clk), .reset(reset),
		.reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .tick_evt(tick_evt),
		.tmr_evt(tmr_evt), .chain_evt(chain_evt), .svc(svc),
		.irq_req_q(irq_req_q));
	iefb_core_model core_u (.core_clk(core_clk), .reset(reset),
		.irq_req_q(irq_req_q), .lag(lag), .svc(svc));

	// ======================================================================
	// clock, watchdog and verdict
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// whole run is under a thousand cycles; five thousand means a hang
	initial begin
		#200000;
		fails++;
		complete_run();
	end

	task automatic complete_run();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ======================================================================
	// register port and event tasks, all driven at the falling edge
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_irq(input logic [4:0] got, input logic [4:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t irq got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		@(negedge core_clk);
		reg_req.wr = 1'b1;
		reg_req.sel = sel;
		reg_req.wdata = d;
		@(negedge core_clk);
		reg_req.wr = 1'b0;
	endtask

	// read data lags the select by one edge
	task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
		@(negedge core_clk);
		reg_req.sel = sel;
		@(negedge core_clk);
		check(reg_rdata_q, exp);
	endtask

	task automatic fire(input logic t, input logic [5:0] tm,
			input logic [3:0] ch);
		@(negedge core_clk);
		tick_evt = t;
		tmr_evt = iefb_pkg::iefb_tmr_evt_t'(tm);
		chain_evt = iefb_pkg::iefb_chain_evt_t'(ch);
		@(negedge core_clk);
		tick_evt = 1'b0;
		tmr_evt = iefb_pkg::iefb_tmr_evt_t'(6'h00);
		chain_evt = iefb_pkg::iefb_chain_evt_t'(4'h0);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// ======================================================================
	// main sequence
	initial begin
		reset = 1'b1;
		reg_req = '0;
		tick_evt = 1'b0;
		tmr_evt = '0;
		chain_evt = '0;
		lag = 4'ha;
		fails = 0;
		compares = 0;
		idle(3);
		reset = 1'b0;
		// reset values, unmapped place included
		for (int s = 0; s < 6; s++) begin
			rd(s[2:0], 8'h00);
		end
		$display("reset values done");
		// every bit written high; unimplemented bits and unmapped read 0
		for (int s = 0; s < 6; s++) begin
			wr(s[2:0], 8'hff);
			rd(s[2:0], s == 0 ? 8'h7f : s == 5 ? 8'h00 : 8'h33);
			wr(s[2:0], 8'h00);
		end
		// timer writes above left group flags set; clear them
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h00);
		$display("access kinds done");
		// tick flag recorded while disabled, then delivered and serviced
		fire(1'b1, 6'h00, 4'h0);
		idle(2);
		check_irq(irq_req_q, 5'h00);
		rd(3'h0, 8'h10);
		wr(3'h0, 8'h13);
		idle(2);
		check_irq(irq_req_q, 5'h08);
		idle(16);
		check_irq(irq_req_q, 5'h00);
		rd(3'h0, 8'h02);
		$display("tick test done");
		// a set and a clearing write in one cycle: the set wins
		@(negedge core_clk);
		reg_req.wr = 1'b1;
		reg_req.sel = 3'h0;
		reg_req.wdata = 8'h00;
		tick_evt = 1'b1;
		@(negedge core_clk);
		reg_req.wr = 1'b0;
		tick_evt = 1'b0;
		rd(3'h0, 8'h10);
		// flag and enable but global off: nothing delivered
		wr(3'h0, 8'h12);
		idle(3);
		check_irq(irq_req_q, 5'h00);
		lag = 4'h0;
		wr(3'h0, 8'h13);
		idle(6);
		rd(3'h0, 8'h02);
		lag = 4'ha;
		$display("global enable test done");
		// each timer source feeds its group; service keeps the source
		for (int n = 0; n < 3; n++) begin
			for (int k = 0; k < 2; k++) begin
				wr(3'h0, 8'h0d);
				wr(3'h1, 8'h01);
				wr(3'(2 + n), k ? 8'h02 : 8'h01);
				fire(1'b0, k ? (6'h01 << n) : (6'h08 << n), 4'h0);
				idle(3);
				check_irq(irq_req_q, 5'(1 << n));
				idle(16);
				rd(3'(2 + n), k ? 8'h22 : 8'h11);
				rd(3'h0, 8'h0c);
				rd(3'h1, 8'h01);
				wr(3'(2 + n), 8'h00);
				fire(1'b0, k ? (6'h01 << n) : (6'h08 << n), 4'h0);
				idle(3);
				rd(3'(2 + n), k ? 8'h20 : 8'h10);
				rd(3'h0, 8'h0c);
				rd(3'h1, 8'h01);
				wr(3'(2 + n), 8'h00);
				wr(3'h0, 8'h00);
			end
		end
		// group 2 enable was left on by the loop
		wr(3'h1, 8'h00);
		$display("timer group test done");
		// each of the four transceiver events raises the shared chain flag
		for (int k = 0; k < 4; k++) begin
			fire(1'b0, 6'h00, 4'h8 >> k);
			rd(3'h1, 8'h20);
			wr(3'h1, 8'h00);
			rd(3'h1, 8'h00);
		end
		// enabled transceiver request is delivered, then serviced
		wr(3'h1, 8'h02);
		wr(3'h0, 8'h01);
		fire(1'b0, 6'h00, 4'h1);
		idle(3);
		check_irq(irq_req_q, 5'h10);
		idle(16);
		rd(3'h1, 8'h02);
		rd(3'h0, 8'h00);
		$display("transceiver test done");
		// a reset in mid-run clears every bit again
		wr(3'h0, 8'h7e);
		@(negedge core_clk);
		reset = 1'b1;
		idle(2);
		reset = 1'b0;
		check_irq(irq_req_q, 5'h00);
		for (int s = 0; s < 5; s++) begin
			rd(s[2:0], 8'h00);
		end
		$display("mid-run reset done");
		complete_run();
	end
endmodule // iefb_irq_bank_tb_top
